// File: hdl/psc_regs.svh
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

// Instruction word codes (10-bit; PSC_OP_SEQ_IMM2H is the 6-bit upper part of the second word)
`define PSC_OP_SET_C     10'h28d
`define PSC_OP_SET_D     10'h015
`define PSC_OP_SEQ_IMM   10'h025
`define PSC_OP_SEQ_IMM2H 6'h07
`define PSC_OP_SEQ_MEM   10'h026
// Top bit of the immediate field and of the Y bit select
`define PSC_IMM_HI       3
`define PSC_YSEL_HI      2
// Port D width and highest legal bit index
`define PSC_PORTD_W      6
`define PSC_PORTD_MAX    4'h5
// Reset levels
`define PSC_PORTC_RST    1'h0
`define PSC_PORTD_RST    6'h00

`endif

// File: hdl/psc_pkg.sv
package psc_pkg;
	typedef enum logic [0:0] {
		PSC_FIRST,
		PSC_IMM_WORD
	} psc_state_t;
endpackage : psc_pkg

// File: hdl/psc_exec.sv
`timescale 1ns/1ps
`include "psc_regs.svh"

module psc_exec (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      instr_valid,
	input  wire logic [9:0]                instr,
	input  wire logic [3:0]                acc,
	input  wire logic [3:0]                index_y,
	input  wire logic [3:0]                mem_data,
	output logic                           port_c,
	output logic [`PSC_PORTD_W-1:0]        port_d,
	output logic                           skip_next,
	output logic                           busy
);

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic is_op(input logic [9:0] w, input logic [9:0] code);
		is_op = (w == code);
	endfunction : is_op

	psc_pkg::psc_state_t state;
	psc_pkg::psc_state_t next_state;
	logic                              next_port_c;
	logic [`PSC_PORTD_W-1:0]           next_port_d;
	logic                              next_skip;
	logic                              next_busy;

	// ----------------------------------------
	// Field helpers
	// ----------------------------------------
	function automatic logic y_in_range(input logic [3:0] y);
		y_in_range = (y <= `PSC_PORTD_MAX);
	endfunction : y_in_range

	logic [`PSC_IMM_HI:0]              imm_field;
	logic [`PSC_YSEL_HI:0]             y_bit;
	logic                              take_first;
	logic                              take_second;
	logic                              take_mem;

	assign imm_field   = instr[`PSC_IMM_HI:0];
	assign y_bit       = index_y[`PSC_YSEL_HI:0];
	assign take_first  = instr_valid && (state == psc_pkg::PSC_FIRST);
	assign take_second = instr_valid && (state == psc_pkg::PSC_IMM_WORD);
	assign take_mem    = take_first && is_op(instr, `PSC_OP_SEQ_MEM);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_state  = state;
		next_port_c = port_c;
		next_port_d = port_d;
		next_skip   = 1'b0;
		next_busy   = 1'b0;
		unique case (state)
			psc_pkg::PSC_FIRST: begin
				if (instr_valid) begin
					if (is_op(instr, `PSC_OP_SET_C)) begin
						next_port_c = 1'b1;
					end else if (is_op(instr, `PSC_OP_SET_D)) begin
						if (y_in_range(index_y)) begin
							next_port_d[y_bit] = 1'b1;
						end
					end else if (is_op(instr, `PSC_OP_SEQ_IMM)) begin
						next_state = psc_pkg::PSC_IMM_WORD;
						next_busy  = 1'b1;
					end else if (is_op(instr, `PSC_OP_SEQ_MEM)) begin
						next_skip = (acc == mem_data);
					end
				end
			end
			psc_pkg::PSC_IMM_WORD: begin
				next_busy = 1'b1;
				if (instr_valid) begin
					next_state = psc_pkg::PSC_FIRST;
					next_busy  = 1'b0;
					next_skip  = (acc == imm_field);
				end
			end
		endcase
	end

	// ----------------------------------------
	// Registers; acc and memory are inputs only
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state     <= psc_pkg::PSC_FIRST;
			port_c    <= `PSC_PORTC_RST;
			port_d    <= `PSC_PORTD_RST;
			skip_next <= 1'b0;
			busy      <= 1'b0;
		end else begin
			state     <= next_state;
			port_c    <= next_port_c;
			port_d    <= next_port_d;
			skip_next <= next_skip;
			busy      <= next_busy;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_imm_pair;
		instr_valid && state == psc_pkg::PSC_FIRST && instr == `PSC_OP_SEQ_IMM
		##1 instr_valid;
	endsequence

	chk_set_c_high: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && state == psc_pkg::PSC_FIRST && instr == `PSC_OP_SET_C
		|=> port_c && !skip_next)
		else $error("port C not set");

	chk_set_d_bit: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && state == psc_pkg::PSC_FIRST && instr == `PSC_OP_SET_D
		&& index_y <= `PSC_PORTD_MAX |=> port_d[$past(y_bit)] && !skip_next)
		else $error("port D bit not set");

	chk_set_d_nop: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && state == psc_pkg::PSC_FIRST && instr == `PSC_OP_SET_D
		&& index_y > `PSC_PORTD_MAX |=> $stable(port_d) && $stable(port_c))
		else $error("port D changed for bad Y");

	chk_imm_two_cyc: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && state == psc_pkg::PSC_FIRST && instr == `PSC_OP_SEQ_IMM
		|=> busy && !skip_next)
		else $error("immediate compare not two words");

	chk_imm_skip: assert property (@(posedge clk) disable iff (!rst_n)
		s_imm_pair |=> skip_next == ($past(acc) == $past(imm_field)))
		else $error("immediate skip wrong");

	chk_mem_skip: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && state == psc_pkg::PSC_FIRST && instr == `PSC_OP_SEQ_MEM
		|=> skip_next == ($past(acc) == $past(mem_data)) && !busy)
		else $error("memory skip wrong");

	chk_cmp_ports: assert property (@(posedge clk) disable iff (!rst_n)
		instr_valid && (instr == `PSC_OP_SEQ_MEM || state == psc_pkg::PSC_IMM_WORD)
		|=> $stable(port_c) && $stable(port_d))
		else $error("compare altered ports");

	chk_port_c_hold: assert property (@(posedge clk) disable iff (!rst_n)
		port_c |=> port_c)
		else $error("port C cleared");

	// ----------------------------------------
	// Further checks
	// ----------------------------------------

	sequence s_imm_open;
		take_first && instr == `PSC_OP_SEQ_IMM;
	endsequence

	sequence s_imm_gap;
		s_imm_open ##1 !instr_valid ##1 instr_valid;
	endsequence

	chk_imm_second: assert property (@(posedge clk) disable iff (!rst_n)
		take_second |=> skip_next == ($past(acc) == $past(imm_field)) && !busy)
		else $error("second word compare wrong");

	chk_imm_gap: assert property (@(posedge clk) disable iff (!rst_n)
		s_imm_gap |=> skip_next == ($past(acc) == $past(imm_field)))
		else $error("compare after gap wrong");

	chk_imm_wait: assert property (@(posedge clk) disable iff (!rst_n)
		state == psc_pkg::PSC_IMM_WORD && !instr_valid
		|=> busy && !skip_next && $stable(port_c) && $stable(port_d))
		else $error("wait for second word broken");

	chk_imm_no_port: assert property (@(posedge clk) disable iff (!rst_n)
		s_imm_open |=> $stable(port_c) && $stable(port_d))
		else $error("first compare word altered ports");

	chk_set_c_only: assert property (@(posedge clk) disable iff (!rst_n)
		take_first && instr == `PSC_OP_SET_C |=> $stable(port_d) && !busy)
		else $error("set C touched port D");

	chk_set_d_others: assert property (@(posedge clk) disable iff (!rst_n)
		take_first && instr == `PSC_OP_SET_D && y_in_range(index_y)
		|=> port_d == ($past(port_d) | (6'h01 << $past(y_bit))) && !busy)
		else $error("set D touched other bits");

	chk_port_d_hold: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> (port_d & $past(port_d)) == $past(port_d))
		else $error("port D bit cleared");

	chk_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
		!instr_valid && state == psc_pkg::PSC_FIRST
		|=> !skip_next && !busy && $stable(port_c) && $stable(port_d))
		else $error("idle cycle changed state");

	chk_unknown_nop: assert property (@(posedge clk) disable iff (!rst_n)
		take_first && instr != `PSC_OP_SET_C && instr != `PSC_OP_SET_D
		&& instr != `PSC_OP_SEQ_IMM && instr != `PSC_OP_SEQ_MEM
		|=> !skip_next && !busy && $stable(port_c) && $stable(port_d))
		else $error("unknown word changed state");

	chk_skip_cause: assert property (@(posedge clk) disable iff (!rst_n)
		skip_next |-> $past(take_second) || $past(take_mem))
		else $error("skip without a compare");

	chk_reset_clear: assert property (@(posedge clk)
		!rst_n |=> port_c == `PSC_PORTC_RST && port_d == `PSC_PORTD_RST && !skip_next && !busy)
		else $error("reset did not clear outputs");

endmodule : psc_exec

// File: sim/psc_mem_model.sv
`timescale 1ns/1ps
module psc_mem_model (
	input  wire logic [3:0] data_pointer,
	output logic      [3:0] mem_data
);
	logic [3:0] mem [16];
	// Read-only store
	initial for (int i = 0; i < 16; i++) mem[i] = 4'(i * 7 + 3);
	assign mem_data = mem[data_pointer];
endmodule : psc_mem_model

// File: sim/port_set_and_compare_skip_ops_tb_top.sv
`timescale 1ns/1ps
`include "psc_regs.svh"
module port_set_and_compare_skip_ops_tb_top;
	logic       clk = 0, rst_n = 0, instr_valid = 0;
	logic [9:0] instr = 10'h000;
	logic [3:0] acc = 4'h0, index_y = 4'h0, dp = 4'h0, mem_data;
	logic       port_c, skip_next, busy, e_c = 0, e_s = 0, e_b = 0;
	logic [5:0] port_d, e_d = 6'h00;
	int         miscompares = 0, checks_done = 0, seed = 32'h1a05336a;
	logic [9:0] ops [5] = '{`PSC_OP_SET_C, `PSC_OP_SET_D, `PSC_OP_SEQ_IMM, `PSC_OP_SEQ_MEM, 10'h000};
	psc_exec uut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
		.acc(acc), .index_y(index_y), .mem_data(mem_data), .port_c(port_c),
		.port_d(port_d), .skip_next(skip_next), .busy(busy));
	psc_mem_model mem (.data_pointer(dp), .mem_data(mem_data));
	initial forever #20 clk = ~clk;
	task cmp(string nm, logic [5:0] e, logic [5:0] s);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : cmp
	task results;
		if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : results
	// ------------------------------
	// Drive one cycle, check the last
	// ------------------------------
	task step(logic v, logic [9:0] w);
		instr_valid <= v;
		instr       <= w;
		#1;
		cmp("port_c", 6'(e_c), 6'(port_c));
		cmp("port_d", e_d, port_d);
		cmp("skip", 6'(e_s), 6'(skip_next));
		cmp("busy", 6'(e_b), 6'(busy));
		e_s = 0;
		if (v && e_b) begin
			e_s = (acc == w[3:0]);
			e_b = 0;
		end
		else if (v && w === `PSC_OP_SET_C) e_c = 1;
		else if (v && w === `PSC_OP_SET_D && index_y <= `PSC_PORTD_MAX) e_d[index_y] = 1;
		else if (v && w === `PSC_OP_SEQ_IMM) e_b = 1;
		else if (v && w === `PSC_OP_SEQ_MEM) e_s = (acc == mem_data);
		@(posedge clk);
	endtask : step
	initial begin
		int r;
		logic [9:0] w;
		repeat (20) @(posedge clk);
		rst_n <= 1;
		for (int i = 0; i < 800; i++) begin
			r = $random(seed);
			// Accumulator held steady across the two compare words
			if (!e_b) acc <= 4'(r >> 12);
			index_y <= 4'(r >> 16);
			dp      <= 4'(r >> 20);
			w = e_b ? {`PSC_OP_SEQ_IMM2H, r[0] ? acc : 4'(r >> 24)} : ops[32'(r[6:4]) % 5];
			step(r[10:8] != 3'h0, w);
		end
		step(1'b0, 10'h000);
		results;
	end
	initial begin
		#100000;
		miscompares++;
		results;
	end
endmodule : port_set_and_compare_skip_ops_tb_top
